// ===== inc/dtm_pkg.sv
// dtm_pkg: offsets, field positions, reset values and clock source codes
// for the dual down counter timer block.
// assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
package dtm_pkg;
  // register byte addresses
  localparam logic [7:0] DTM_OFS_CTRL  = 8'h00;
  localparam logic [7:0] DTM_OFS_MODE  = 8'h04;
  localparam logic [7:0] DTM_OFS_CSEL  = 8'h08;
  localparam logic [7:0] DTM_OFS_RUNF  = 8'h0C;
  localparam logic [7:0] DTM_OFS_T0LO  = 8'h10;
  localparam logic [7:0] DTM_OFS_T0HI  = 8'h14;
  localparam logic [7:0] DTM_OFS_T1LO  = 8'h18;
  localparam logic [7:0] DTM_OFS_T1HI  = 8'h1C;
  // control register fields
  localparam int DTM_B_EN   = 0;
  localparam int DTM_B_XEN  = 1;
  // run / full register fields
  localparam int DTM_B_RUN0  = 0;
  localparam int DTM_B_FULL0 = 1;
  localparam int DTM_B_RUN1  = 2;
  localparam int DTM_B_FULL1 = 3;
  // clock select field positions
  localparam int DTM_B_SEL0 = 0;
  localparam int DTM_B_SEL1 = 4;
  // reset values
  localparam logic [7:0] DTM_RST_BYTE = 8'h00;
  localparam logic [2:0] DTM_RST_MODE = 3'h0;
  localparam logic [3:0] DTM_RST_SEL  = 4'h0;
  // timer modes
  localparam logic [2:0] DTM_M0 = 3'h0;
  localparam logic [2:0] DTM_M1 = 3'h1;
  localparam logic [2:0] DTM_M2 = 3'h2;
  localparam logic [2:0] DTM_M3 = 3'h3;
  localparam logic [2:0] DTM_M4 = 3'h4;
  localparam logic [2:0] DTM_M5 = 3'h5;
  localparam logic [2:0] DTM_M6 = 3'h6;
  localparam logic [2:0] DTM_M7 = 3'h7;
  // clock source codes (index into the tick vector)
  localparam int DTM_SRC_RC1    = 0;
  localparam int DTM_SRC_RC8    = 1;
  localparam int DTM_SRC_RC32   = 2;
  localparam int DTM_SRC_RC128  = 3;
  localparam int DTM_SRC_RC512  = 4;
  localparam int DTM_SRC_LP     = 5;
  localparam int DTM_SRC_XD6    = 6;
  localparam int DTM_SRC_CHAIN  = 7;
  localparam int DTM_SRC_XD512  = 8;
  localparam int DTM_SRC_RC90D8 = 9;
  // prescaler masks (divisor minus one)
  localparam logic [8:0] DTM_DIV8   = 9'h007;
  localparam logic [8:0] DTM_DIV32  = 9'h01F;
  localparam logic [8:0] DTM_DIV128 = 9'h07F;
  localparam logic [8:0] DTM_DIV512 = 9'h1FF;
  localparam logic [2:0] DTM_XDIV6  = 3'h5;
  localparam logic [2:0] DTM_R90D8  = 3'h7;
  // AXI responses
  localparam logic [1:0] DTM_OKAY   = 2'h0;
  localparam logic [1:0] DTM_SLVERR = 2'h2;
endpackage

// ===== logic/dtm_timer.sv
// dtm_timer: two down counting timers behind an AXI4-Lite slave.
// assumes oscillator ticks and the wake pin arrive synchronous to CLK.
// Contract
// - eight timer modes, zero to seven, picked by a three-bit field.
// - each mode fixes 8 or 16 bit length and stop or reload.
// - each byte register is either a down counter or reload holder.
// - supported splits of the four bytes into timers per mode.
// - no interrupt; software polls the full flags.
// - each timer clock from its select bits and crystal enable.
// - 12 MHz tick divided by 1, 8, 32, 128 or 512, free of system divider.
// - 4.4 kHz tick taken from both edges of the 2.2 kHz oscillator.
// - timer 0 may count timer 1 underflows.
// - timer 1 may count rising edges on the wake pin.
// - either timer may count crystal ticks divided by six.
// - timer 0 may count crystal ticks divided by 512.
// - timer 0 may count 90 kHz ticks divided by eight.
// - registers load on the system clock, not the counting clock.
// - firmware disables the block before handing back control.
// - single-run timer counts from loaded value to zero, then stops.
// - underflow happens on the counting tick after reaching zero.
// - single-run underflow clears the run bit and sets full.
// - reloading timer copies reload value into counter at underflow.
// - reloading timer sets full; software clears it, runs and stops it.
// - mode zero: 16 bit reload timer 0, reload in timer 1 bytes.
// - modes one to three drive a baud tick from timer 1 underflow.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module dtm_timer (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic        RC12_TICK,
  input  wire logic        LP_OSC,
  input  wire logic        RC90_TICK,
  input  wire logic        XTAL_TICK,
  input  wire logic        WAKE_IN,
  output logic             BAUD_TICK
);
  import dtm_pkg::*;

  // software visible state
  logic       en;
  logic       xen;
  logic [2:0] mode;
  logic [3:0] sel0;
  logic [3:0] sel1;
  logic       run0;
  logic       full0;
  logic       run1;
  logic       full1;
  logic [7:0] tl0;
  logic [7:0] th0;
  logic [7:0] tl1;
  logic [7:0] th1;
  // bus state
  logic       aw_hold;
  logic       w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // prescalers and edge history
  logic [8:0] rc_cnt;
  logic [2:0] x6_cnt;
  logic [8:0] x512_cnt;
  logic [2:0] r90_cnt;
  logic       lp_prev;
  logic       wake_prev;

  // tick selection, used for both timers
  function automatic logic pick_tick(input logic [15:0] v, input logic [3:0] s);
    pick_tick = v[s];
  endfunction

  // bus handshake decode
  wire aw_take = AWVALID & AWREADY;
  wire w_take  = WVALID & WREADY;
  wire ar_take = ARVALID & ARREADY;
  wire wr_do   = aw_hold & w_hold & ~BVALID;
  wire next_aw_hold = (aw_hold | aw_take) & ~wr_do;
  wire next_w_hold  = (w_hold | w_take) & ~wr_do;
  wire next_bvalid  = wr_do | (BVALID & ~BREADY);
  wire next_rvalid  = ar_take | (RVALID & ~RREADY);
  wire ld = wr_do & w_strb[0];
  // write decode; writes land on the system clock edge
  wire wr_ctrl = ld & (aw_addr == DTM_OFS_CTRL);
  wire wr_mode = ld & (aw_addr == DTM_OFS_MODE);
  wire wr_csel = ld & (aw_addr == DTM_OFS_CSEL);
  wire wr_runf = ld & (aw_addr == DTM_OFS_RUNF);
  wire wr_tl0  = ld & (aw_addr == DTM_OFS_T0LO);
  wire wr_th0  = ld & (aw_addr == DTM_OFS_T0HI);
  wire wr_tl1  = ld & (aw_addr == DTM_OFS_T1LO);
  wire wr_th1  = ld & (aw_addr == DTM_OFS_T1HI);
  wire wr_any  = wr_tl0 | wr_th0 | wr_tl1 | wr_th1;
  wire wr_bad  = aw_addr[1:0] != 2'h0 || aw_addr > DTM_OFS_T1HI;
  wire [7:0] wb = w_data[7:0];

  // mode decode: what each byte pair does in each mode
  wire t0_used = mode != DTM_M4 && mode != DTM_M7;
  wire t0_16   = mode == DTM_M0 || mode == DTM_M1 || mode == DTM_M6;
  wire t0_rel  = mode == DTM_M0 || mode == DTM_M2 || mode == DTM_M5;
  wire tb_used = mode == DTM_M3;
  wire t1_used = mode != DTM_M0 && mode != DTM_M7;
  wire t1_16   = mode == DTM_M4 || mode == DTM_M5 || mode == DTM_M6;
  wire t1_rel  = mode >= DTM_M1 && mode <= DTM_M4;
  wire baud_md = mode >= DTM_M1 && mode <= DTM_M3;
  // in mode three the timer 1 run bit belongs to the second 8 bit half
  wire t1_run  = tb_used ? en : run1;
  // reload sources per mode
  wire [15:0] rel0 = t0_16 ? {th1, tl1} : {8'h00, th0};
  wire [15:0] rel1 = t1_16 ? {th0, tl0} : {8'h00, th1};

  // prescaled 12 MHz ticks, independent of any system divider
  wire rc1   = RC12_TICK;
  wire rc8   = RC12_TICK & ((rc_cnt & DTM_DIV8) == DTM_DIV8);
  wire rc32  = RC12_TICK & ((rc_cnt & DTM_DIV32) == DTM_DIV32);
  wire rc128 = RC12_TICK & ((rc_cnt & DTM_DIV128) == DTM_DIV128);
  wire rc512 = RC12_TICK & (rc_cnt == DTM_DIV512);
  // either edge of the 2.2 kHz wave gives the 4.4 kHz tick
  wire lp_tick = LP_OSC ^ lp_prev;
  wire wake_rise = WAKE_IN & ~wake_prev;
  // crystal ticks only pass while the crystal enable is set
  wire xt    = XTAL_TICK & xen;
  wire xd6   = xt & (x6_cnt == DTM_XDIV6);
  wire xd512 = xt & (x512_cnt == DTM_DIV512);
  wire r90d8 = RC90_TICK & (r90_cnt == DTM_R90D8);

  // timer 1 first, so timer 0 can chain on its underflow
  wire [15:0] c1 = {th1, tl1};
  wire c1_zero = t1_16 ? (c1 == 16'h0000) : (tl1 == 8'h00);
  wire [15:0] src1 = {6'h00, 1'b0, 1'b0, wake_rise, xd6, lp_tick,
                      rc512, rc128, rc32, rc8, rc1};
  wire tk1 = pick_tick(src1, sel1);
  wire cnt1 = en & t1_used & t1_run & tk1;
  wire uf1 = cnt1 & c1_zero;
  wire [15:0] dec1 = c1 - 16'h0001;

  wire [15:0] c0 = {th0, tl0};
  wire c0_zero = t0_16 ? (c0 == 16'h0000) : (tl0 == 8'h00);
  wire [15:0] src0 = {6'h00, r90d8, xd512, uf1, xd6, lp_tick,
                      rc512, rc128, rc32, rc8, rc1};
  wire tk0 = pick_tick(src0, sel0);
  wire cnt0 = en & t0_used & run0 & tk0;
  wire uf0 = cnt0 & c0_zero;
  wire [15:0] dec0 = c0 - 16'h0001;
  // second 8 bit half of mode three, single run on the timer 1 flags
  wire cntb = en & tb_used & run1 & tk0;
  wire ufb = cntb & (th0 == 8'h00);

  // next byte values: a software load beats counting in the same cycle
  wire [15:0] n0 = uf0 ? (t0_rel ? rel0 : 16'h0000) : dec0;
  wire [15:0] n1 = uf1 ? (t1_rel ? rel1 : 16'h0000) : dec1;
  wire [7:0] next_tl0 = wr_tl0 ? wb : cnt0 ? n0[7:0] : tl0;
  wire [7:0] next_th0 = wr_th0 ? wb
                      : (cnt0 & t0_16) ? n0[15:8]
                      : (cntb & ~ufb) ? th0 - 8'h01 : th0;
  wire [7:0] next_tl1 = wr_tl1 ? wb : cnt1 ? n1[7:0] : tl1;
  wire [7:0] next_th1 = wr_th1 ? wb : (cnt1 & t1_16) ? n1[15:8] : th1;

  // run and full flags: a hardware stop beats a software run, a hardware full set beats a software clear
  wire sw_run0  = wr_runf ? wb[DTM_B_RUN0] : run0;
  wire sw_run1  = wr_runf ? wb[DTM_B_RUN1] : run1;
  wire sw_full0 = wr_runf ? full0 & wb[DTM_B_FULL0] : full0;
  wire sw_full1 = wr_runf ? full1 & wb[DTM_B_FULL1] : full1;
  wire stop0 = uf0 & ~t0_rel;
  wire stop1 = (uf1 & ~t1_rel & ~tb_used) | ufb;
  wire next_run0  = sw_run0 & ~stop0;
  wire next_run1  = sw_run1 & ~stop1;
  wire next_full0 = sw_full0 | uf0;
  wire next_full1 = sw_full1 | ufb | (uf1 & ~tb_used);

  // read decode; unmapped addresses answer zero with an error
  wire [7:0] ra = ARADDR;
  wire rd_bad = ra[1:0] != 2'h0 || ra > DTM_OFS_T1HI;
  wire [7:0] rd_byte =
      (ra == DTM_OFS_CTRL) ? {6'h00, xen, en}
    : (ra == DTM_OFS_MODE) ? {5'h00, mode}
    : (ra == DTM_OFS_CSEL) ? {sel1, sel0}
    : (ra == DTM_OFS_RUNF) ? {4'h0, full1, run1, full0, run0}
    : (ra == DTM_OFS_T0LO) ? tl0
    : (ra == DTM_OFS_T0HI) ? th0
    : (ra == DTM_OFS_T1LO) ? tl1
    : (ra == DTM_OFS_T1HI) ? th1 : 8'h00;

  // write channel holding and response
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= DTM_OKAY;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold  <= next_w_hold;
      AWREADY <= ~next_aw_hold & ~next_bvalid;
      WREADY  <= ~next_w_hold & ~next_bvalid;
      BVALID  <= next_bvalid;
      if (wr_do) BRESP <= wr_bad ? DTM_SLVERR : DTM_OKAY;
    end
  end

  // write payload capture
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) aw_addr <= AWADDR;
      if (w_take) begin
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
    end
  end

  // read channel: data one edge after the address is taken
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0000_0000;
      RRESP   <= DTM_OKAY;
    end else begin
      ARREADY <= ~next_rvalid;
      RVALID  <= next_rvalid;
      if (ar_take) begin
        RDATA <= {24'h00_0000, rd_byte};
        RRESP <= rd_bad ? DTM_SLVERR : DTM_OKAY;
      end
    end
  end

  // configuration registers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en   <= 1'b0;
      xen  <= 1'b0;
      mode <= DTM_RST_MODE;
      sel0 <= DTM_RST_SEL;
      sel1 <= DTM_RST_SEL;
    end else begin
      if (wr_ctrl) begin
        en  <= wb[DTM_B_EN];
        xen <= wb[DTM_B_XEN];
      end
      if (wr_mode) mode <= wb[2:0];
      if (wr_csel) begin
        sel0 <= wb[DTM_B_SEL0 +: 4];
        sel1 <= wb[DTM_B_SEL1 +: 4];
      end
    end
  end

  // counters and flags
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tl0   <= DTM_RST_BYTE;
      th0   <= DTM_RST_BYTE;
      tl1   <= DTM_RST_BYTE;
      th1   <= DTM_RST_BYTE;
      run0  <= 1'b0;
      run1  <= 1'b0;
      full0 <= 1'b0;
      full1 <= 1'b0;
    end else begin
      tl0   <= next_tl0;
      th0   <= next_th0;
      tl1   <= next_tl1;
      th1   <= next_th1;
      run0  <= next_run0;
      run1  <= next_run1;
      full0 <= next_full0;
      full1 <= next_full1;
    end
  end

  // prescalers keep running while disabled so restarts stay cheap
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rc_cnt    <= 9'h000;
      x6_cnt    <= 3'h0;
      x512_cnt  <= 9'h000;
      r90_cnt   <= 3'h0;
      lp_prev   <= 1'b0;
      wake_prev <= 1'b0;
    end else begin
      if (RC12_TICK) rc_cnt <= rc_cnt + 9'h001;
      if (xt) x6_cnt <= (x6_cnt == DTM_XDIV6) ? 3'h0 : x6_cnt + 3'h1;
      if (xt) x512_cnt <= x512_cnt + 9'h001;
      if (RC90_TICK) r90_cnt <= r90_cnt + 3'h1;
      lp_prev   <= LP_OSC;
      wake_prev <= WAKE_IN;
    end
  end

  // baud tick for the transmitter, only in the modes that provide it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      BAUD_TICK <= 1'b0;
    end else begin
      BAUD_TICK <= uf1 & baud_md;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_single_stop;
    (uf0 && !t0_rel) |=> (!run0 && full0);
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("run not cleared");

  property p_reload16;
    (uf0 && t0_rel && t0_16 && !wr_any) |=> ({th0, tl0} == $past({th1, tl1}));
  endproperty
  a_reload16: assert property (p_reload16) else $error("reload value lost");

  property p_reach_zero;
    (cnt0 && t0_16 && c0 == 16'h0001 && !wr_any) |=> (c0 == 16'h0000 && !$rose(full0));
  endproperty
  a_reach_zero: assert property (p_reach_zero) else $error("early underflow");

  property p_disabled;
    (!en && !wr_any) |=> $stable({tl0, th0, tl1, th1});
  endproperty
  a_disabled: assert property (p_disabled) else $error("counted while off");

  property p_baud;
    BAUD_TICK |-> ($past(uf1) && $past(mode) >= DTM_M1 && $past(mode) <= DTM_M3);
  endproperty
  a_baud: assert property (p_baud) else $error("stray baud tick");

  property p_mode7;
    (mode == DTM_M7) |-> (!uf0 && !uf1 && !ufb);
  endproperty
  a_mode7: assert property (p_mode7) else $error("mode seven counted");

  property p_full_wins;
    (wr_runf && !wb[DTM_B_FULL0] && uf0) |=> full0;
  endproperty
  a_full_wins: assert property (p_full_wins) else $error("full flag lost");

  property p_mode0_idle;
    (mode == DTM_M0 && !wr_any) |=> $stable({th1, tl1});
  endproperty
  a_mode0_idle: assert property (p_mode0_idle) else $error("reload bytes moved");

  property p_rd_answer;
    (ARVALID && ARREADY) |=> RVALID;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");

  property p_b_hold;
    (BVALID && !BREADY) |=> (BVALID && $stable(BRESP));
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");

  c_single: cover property (uf0 && !t0_rel);
  c_reload: cover property (uf1 && t1_rel);
  c_chain: cover property (cnt0 && sel0 == 4'h7);
  c_baud: cover property (BAUD_TICK);
endmodule

// ===== tb/dtm_timer_tb.sv
// dtm_timer_tb: self-checking bench for the dual down counter timer block.
// assumes dtm_pkg offsets; drives the register bus and every tick input itself.
`timescale 1ns/1ps
module dtm_timer_tb;
  import dtm_pkg::*;
  logic        CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, BAUD_TICK;
  logic [7:0]  AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA;
  logic [3:0]  WSTRB;
  logic [1:0]  BRESP, RRESP;
  logic        RC12_TICK, LP_OSC, RC90_TICK, XTAL_TICK, WAKE_IN;
  int          n_mismatch, checks_done, n_baud;
  logic [3:0]  wr_strb;

  dtm_timer u_dut (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .RC12_TICK(RC12_TICK), .LP_OSC(LP_OSC), .RC90_TICK(RC90_TICK), .XTAL_TICK(XTAL_TICK),
    .WAKE_IN(WAKE_IN), .BAUD_TICK(BAUD_TICK));

  always #5 CLK = ~CLK;

  // baud pulses are one cycle wide, so every edge must be looked at
  always @(posedge CLK) begin
    if (BAUD_TICK === 1'h1) n_baud <= n_baud + 1;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // handshakes are judged at the falling edge: the same values the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ta, tw, tb, db;
    int n;
    db = 0;
    n = 0;
    @(posedge CLK);
    AWADDR <= a; AWVALID <= 1'h1; WDATA <= d; WSTRB <= wr_strb; WVALID <= 1'h1; BREADY <= 1'h1;
    while (!db && n < 100) begin
      @(negedge CLK);
      ta = AWVALID && (AWREADY === 1'h1);
      tw = WVALID && (WREADY === 1'h1);
      tb = BREADY && (BVALID === 1'h1);
      if (tb) chk("bresp", {30'h0, er}, {30'h0, BRESP});
      @(posedge CLK);
      if (ta) AWVALID <= 1'h0;
      if (tw) WVALID <= 1'h0;
      if (tb) begin
        BREADY <= 1'h0;
        db = 1;
      end
      n++;
    end
    if (!db) chk("write_timeout", 32'h1, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    bit ta, tr, dr;
    int n;
    dr = 0;
    n = 0;
    @(posedge CLK);
    ARADDR <= a; ARVALID <= 1'h1; RREADY <= 1'h1;
    while (!dr && n < 100) begin
      @(negedge CLK);
      ta = ARVALID && (ARREADY === 1'h1);
      tr = RREADY && (RVALID === 1'h1);
      if (tr) begin
        chk($sformatf("rdata_%h", a), exp, RDATA);
        chk("rresp", {30'h0, er}, {30'h0, RRESP});
      end
      @(posedge CLK);
      if (ta) ARVALID <= 1'h0;
      if (tr) begin
        RREADY <= 1'h0;
        dr = 1;
      end
      n++;
    end
    if (!dr) chk("read_timeout", 32'h1, 32'h0);
  endtask

  // kind: 0 rc12, 1 crystal, 2 rc90, 3 low power level toggle, 4 wake rising edge
  task automatic pulse(input int k, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      case (k)
        0: RC12_TICK <= 1'h1;
        1: XTAL_TICK <= 1'h1;
        2: RC90_TICK <= 1'h1;
        3: LP_OSC <= !LP_OSC;
        default: WAKE_IN <= 1'h1;
      endcase
      @(posedge CLK);
      RC12_TICK <= 1'h0; XTAL_TICK <= 1'h0; RC90_TICK <= 1'h0; WAKE_IN <= 1'h0;
    end
    repeat (3) @(posedge CLK);
  endtask

  task automatic t_reset_and_fields();
    for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0, DTM_OKAY);
    wr(DTM_OFS_MODE, 32'hFF, DTM_OKAY);
    rd(DTM_OFS_MODE, 32'h7, DTM_OKAY);
    wr(DTM_OFS_T1HI, 32'hFFFFFF3C, DTM_OKAY);
    rd(DTM_OFS_T1HI, 32'h3C, DTM_OKAY);
    wr(8'h20, 32'h1, DTM_SLVERR);
    rd(8'h20, 32'h0, DTM_SLVERR);
    rd(8'h02, 32'h0, DTM_SLVERR);
  endtask

  task automatic setup(input logic [31:0] m, input logic [31:0] sel, input logic [31:0] ctl);
    wr(DTM_OFS_RUNF, 32'h0, DTM_OKAY);
    wr(DTM_OFS_MODE, m, DTM_OKAY);
    wr(DTM_OFS_CSEL, sel, DTM_OKAY);
    wr(DTM_OFS_CTRL, ctl, DTM_OKAY);
  endtask

  // 8 bit reload: gated while disabled, zero reached, underflow one tick later
  task automatic t_reload8();
    setup(DTM_M2, 32'h0, 32'h0);
    wr(DTM_OFS_T0HI, 32'h5, DTM_OKAY);
    wr(DTM_OFS_T0LO, 32'h3, DTM_OKAY);
    wr(DTM_OFS_RUNF, 32'h1, DTM_OKAY);
    pulse(0, 4);
    rd(DTM_OFS_T0LO, 32'h3, DTM_OKAY);
    wr(DTM_OFS_CTRL, 32'h1, DTM_OKAY);
    pulse(0, 3);
    rd(DTM_OFS_T0LO, 32'h0, DTM_OKAY);
    rd(DTM_OFS_RUNF, 32'h1, DTM_OKAY);
    pulse(0, 1);
    rd(DTM_OFS_T0LO, 32'h5, DTM_OKAY);
    rd(DTM_OFS_RUNF, 32'h3, DTM_OKAY);
    wr(DTM_OFS_RUNF, 32'h1, DTM_OKAY);
    rd(DTM_OFS_RUNF, 32'h1, DTM_OKAY);
    wr(DTM_OFS_RUNF, 32'h0, DTM_OKAY);
    pulse(0, 2);
    rd(DTM_OFS_T0LO, 32'h5, DTM_OKAY);
  endtask

  task automatic t_single16();
    setup(DTM_M6, 32'h0, 32'h1);
    wr(DTM_OFS_T0HI, 32'h1, DTM_OKAY);
    wr(DTM_OFS_T0LO, 32'h0, DTM_OKAY);
    wr(DTM_OFS_RUNF, 32'h1, DTM_OKAY);
    pulse(0, 1);
    rd(DTM_OFS_T0LO, 32'hFF, DTM_OKAY);
    rd(DTM_OFS_T0HI, 32'h0, DTM_OKAY);
    wr(DTM_OFS_T0LO, 32'h1, DTM_OKAY);
    pulse(0, 2);
    rd(DTM_OFS_RUNF, 32'h2, DTM_OKAY);
    pulse(0, 2);
    rd(DTM_OFS_T0LO, 32'h0, DTM_OKAY);
  endtask

  task automatic t_mode0();
    setup(DTM_M0, 32'h0, 32'h1);
    wr(DTM_OFS_T1LO, 32'h34, DTM_OKAY);
    wr(DTM_OFS_T1HI, 32'h12, DTM_OKAY);
    wr(DTM_OFS_T0LO, 32'h1, DTM_OKAY);
    wr(DTM_OFS_T0HI, 32'h0, DTM_OKAY);
    wr(DTM_OFS_RUNF, 32'h1, DTM_OKAY);
    pulse(0, 2);
    rd(DTM_OFS_T0LO, 32'h34, DTM_OKAY);
    rd(DTM_OFS_T0HI, 32'h12, DTM_OKAY);
    rd(DTM_OFS_RUNF, 32'h3, DTM_OKAY);
  endtask

  // wake edges clock timer 1, whose underflows clock timer 0 and the baud output
  task automatic t_chain();
    int b0;
    setup(DTM_M1, 32'h77, 32'h1);
    wr(DTM_OFS_T1LO, 32'h0, DTM_OKAY);
    wr(DTM_OFS_T1HI, 32'h0, DTM_OKAY);
    wr(DTM_OFS_T0LO, 32'h1, DTM_OKAY);
    wr(DTM_OFS_T0HI, 32'h0, DTM_OKAY);
    wr(DTM_OFS_RUNF, 32'h5, DTM_OKAY);
    b0 = n_baud;
    pulse(4, 2);
    rd(DTM_OFS_RUNF, 32'hE, DTM_OKAY);
    rd(DTM_OFS_T0LO, 32'h0, DTM_OKAY);
    chk("baud_count", 32'h2, 32'(n_baud - b0));
  endtask

  // one row per source except code 7, code 6 twice (crystal off, on): code, tick kind, pulses, control value, expected decrement
  task automatic t_sources();
    int tab[10][5] = '{'{0, 0, 2, 1, 2}, '{1, 0, 16, 1, 2}, '{2, 0, 64, 1, 2},
      '{3, 0, 256, 1, 2}, '{4, 0, 512, 1, 1}, '{5, 3, 2, 1, 2}, '{6, 1, 12, 1, 0},
      '{6, 1, 12, 3, 2}, '{8, 1, 512, 3, 1}, '{9, 2, 16, 1, 2}};
    for (int i = 0; i < 10; i++) begin
      setup(DTM_M6, 32'(tab[i][0]), 32'(tab[i][3]));
      wr(DTM_OFS_T0LO, 32'h3, DTM_OKAY);
      wr(DTM_OFS_T0HI, 32'h0, DTM_OKAY);
      wr(DTM_OFS_RUNF, 32'h1, DTM_OKAY);
      pulse(tab[i][1], tab[i][2]);
      rd(DTM_OFS_T0LO, 32'(3 - tab[i][4]), DTM_OKAY);
    end
    setup(DTM_M7, 32'h0, 32'h1);
    wr(DTM_OFS_RUNF, 32'h1, DTM_OKAY);
    pulse(0, 3);
    rd(DTM_OFS_T0LO, 32'h1, DTM_OKAY);
  endtask

  // modes 3 to 5 on rc12 ticks; timer 1 runs off source 0 here, a path the chain test skips
  task automatic t_modes345();
    int b0;
    setup(DTM_M3, 32'h0, 32'h1);
    wr(DTM_OFS_T0LO, 32'h2, DTM_OKAY);
    wr(DTM_OFS_T0HI, 32'h1, DTM_OKAY);
    wr(DTM_OFS_T1LO, 32'h0, DTM_OKAY);
    wr(DTM_OFS_T1HI, 32'h3, DTM_OKAY);
    wr(DTM_OFS_RUNF, 32'h5, DTM_OKAY);
    b0 = n_baud;
    pulse(0, 3);
    rd(DTM_OFS_RUNF, 32'hA, DTM_OKAY);
    rd(DTM_OFS_T0HI, 32'h0, DTM_OKAY);
    rd(DTM_OFS_T1LO, 32'h1, DTM_OKAY);
    chk("baud_mode3", 32'h1, 32'(n_baud - b0));
    // mode 4: timer 0 idle, timer 1 reloads sixteen bits from the timer 0 bytes
    setup(DTM_M4, 32'h0, 32'h1);
    wr(DTM_OFS_T0LO, 32'h22, DTM_OKAY);
    wr(DTM_OFS_T0HI, 32'h11, DTM_OKAY);
    wr(DTM_OFS_T1LO, 32'h1, DTM_OKAY);
    wr(DTM_OFS_T1HI, 32'h0, DTM_OKAY);
    wr(DTM_OFS_RUNF, 32'h5, DTM_OKAY);
    b0 = n_baud;
    pulse(0, 2);
    rd(DTM_OFS_T1LO, 32'h22, DTM_OKAY);
    rd(DTM_OFS_T1HI, 32'h11, DTM_OKAY);
    rd(DTM_OFS_T0LO, 32'h22, DTM_OKAY);
    rd(DTM_OFS_RUNF, 32'hD, DTM_OKAY);
    chk("baud_mode4", 32'h0, 32'(n_baud - b0));
    // mode 5: 8 bit reload on timer 0, 16 bit single run on timer 1
    setup(DTM_M5, 32'h0, 32'h1);
    wr(DTM_OFS_T0LO, 32'h1, DTM_OKAY);
    wr(DTM_OFS_T0HI, 32'h7, DTM_OKAY);
    wr(DTM_OFS_T1LO, 32'h1, DTM_OKAY);
    wr(DTM_OFS_T1HI, 32'h0, DTM_OKAY);
    wr(DTM_OFS_RUNF, 32'h5, DTM_OKAY);
    pulse(0, 2);
    rd(DTM_OFS_T0LO, 32'h7, DTM_OKAY);
    rd(DTM_OFS_RUNF, 32'hB, DTM_OKAY);
    // a write with the low strobe off must leave the byte alone
    wr_strb = 4'h0;
    wr(DTM_OFS_T0LO, 32'h55, DTM_OKAY);
    wr_strb = 4'hF;
    rd(DTM_OFS_T0LO, 32'h7, DTM_OKAY);
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // generous bound: the whole sequence needs well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge CLK);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    CLK = 1'h0; RST_N = 1'h0; AWADDR = 8'h00; AWVALID = 1'h0; WDATA = 32'h0; WSTRB = 4'h0;
    WVALID = 1'h0; BREADY = 1'h0; ARADDR = 8'h00; ARVALID = 1'h0; RREADY = 1'h0;
    RC12_TICK = 1'h0; LP_OSC = 1'h0; RC90_TICK = 1'h0; XTAL_TICK = 1'h0; WAKE_IN = 1'h0;
    n_mismatch = 0; checks_done = 0; n_baud = 0;
    wr_strb = 4'hF;
    repeat (16) @(posedge CLK);
    RST_N <= 1'h1;
    repeat (2) @(posedge CLK);
    t_reset_and_fields();
    t_reload8();
    t_single16();
    t_mode0();
    t_chain();
    t_sources();
    t_modes345();
    give_verdict();
  end
endmodule
